// >>> logic/mme_defines.svh
// offsets, field positions and entry values of the management mode entry unit
`ifndef MME_DEFINES_SVH
`define MME_DEFINES_SVH
`define MME_OFF_STATUS 8'h00
`define MME_OFF_BASE 8'h04
`define MME_OFF_CW0 8'h08
`define MME_OFF_CW4 8'h0c
`define MME_OFF_FLAGS 8'h10
`define MME_OFF_IP 8'h14
`define MME_OFF_CSSEL 8'h18
`define MME_OFF_CSBASE 8'h1c
`define MME_OFF_DCTRL 8'h20
`define MME_OFF_RBASE 8'h24
`define MME_OFF_RMASK 8'h28
`define MME_OFF_VTAB 8'h2c
`define MME_OFF_RESUME 8'h30
`define MME_BASE_RST 32'h0003_0000
`define MME_CW0_RST 32'h0000_0000
`define MME_IP_ENTRY 32'h0000_8000
`define MME_FLAGS_ENTRY 32'h0000_0002
`define MME_DCTRL_ENTRY 32'h0000_0400
`define MME_LIMIT_4G 32'hffff_ffff
`define MME_LIMIT_RM 32'h0000_ffff
`define MME_ZERO32 32'h0000_0000
`define MME_BIT_PE 0
`define MME_BIT_EM 2
`define MME_BIT_TS 3
`define MME_BIT_PG 31
`define MME_BIT_TF 8
`define MME_BIT_IF 9
`define MME_BIT_PAE 5
`define MME_RESP_OKAY 2'b00
`define MME_RESP_SLVERR 2'b10
`endif

// >>> logic/mme_pkg.sv
// types of the management mode entry unit
package mme_pkg;
  typedef enum logic [1:0] {
    ST_NORMAL,
    ST_SAVE,
    ST_INIT,
    ST_MGMT
  } mme_state_t;
endpackage

// >>> logic/mme_entry_unit.sv
// management mode entry unit: entry sequence, mode addressing rules, axi4-lite registers
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`include "mme_defines.svh"

module mme_entry_unit
  import mme_pkg::*;
(
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // platform pin
  input wire logic mgmt_irq_req_n,
  // core side
  input wire logic ctx_saved,
  input wire logic op_ovr,
  input wire logic adr_ovr,
  input wire logic xfer_valid,
  input wire logic xfer_far,
  input wire logic xfer_op32,
  input wire logic [15:0] xfer_sel,
  input wire logic [31:0] xfer_off,
  input wire logic int_valid,
  input wire logic [7:0] int_vec,
  input wire logic [15:0] int_sel,
  input wire logic [15:0] int_off,
  input wire logic seg_ld_valid,
  input wire logic [2:0] seg_ld_idx,
  input wire logic [15:0] seg_ld_val,
  input wire logic acc_valid,
  input wire logic [2:0] acc_seg,
  input wire logic [31:0] acc_off,
  input wire logic [31:0] mem_addr,
  // mode and state outputs
  output logic in_mode,
  output logic fetch_start,
  output logic [31:0] fetch_addr,
  output logic [31:0] instr_pointer,
  output logic [15:0] cs_sel,
  output logic [31:0] cs_base,
  output logic [31:0] ctrl_word_zero,
  output logic [31:0] ctrl_word_four,
  output logic [31:0] flags_reg,
  output logic [31:0] debug_ctrl_reg,
  output logic eff_op32,
  output logic eff_adr32,
  output logic phys_addr_ext_en,
  output logic [31:0] acc_lin,
  output logic acc_fault,
  output logic [31:0] vec_addr,
  output logic [15:0] push_ip,
  output logic mem_cacheable,
  // blocking and enables
  output logic nmi_block,
  output logic mgmt_irq_block,
  output logic addr_line20_mask_irq_block,
  output logic init_block,
  output logic intr_enable,
  output logic exc_enable,
  output logic soft_int_enable
);
  localparam int NSEG = 5;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // real-mode base: selector shifted left four, 20 bits at most
  function automatic logic [31:0] rm_base(input logic [15:0] sel);
    return {12'h000, sel, 4'h0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  mme_state_t state;
  logic sy1, sy2, sy3, req_lvl_n;
  logic [31:0] mgmt_base_addr, rng_base, rng_mask;
  logic vt_loaded;
  logic [15:0] seg_sel [NSEG];
  logic [31:0] seg_base [NSEG];
  logic [31:0] seg_limit [NSEG];

  // three-stage pin synchroniser; level changes once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sy1 <= 1'b1;
      sy2 <= 1'b1;
      sy3 <= 1'b1;
      req_lvl_n <= 1'b1;
    end else if (ce) begin
      sy1 <= mgmt_irq_req_n;
      sy2 <= sy1;
      sy3 <= sy2;
      if (sy2 == sy3) begin
        req_lvl_n <= sy3;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic aw_hold, w_hold;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  wire wr_fire = aw_hold && w_hold && !bvalid;
  wire wr_mode_only = (wa == `MME_OFF_RBASE) || (wa == `MME_OFF_RMASK) || (wa == `MME_OFF_VTAB);
  wire wr_mapped = (wa == `MME_OFF_BASE) || (wa == `MME_OFF_CW0) || (wa == `MME_OFF_CW4) ||
                   (wa == `MME_OFF_FLAGS) || (wa == `MME_OFF_DCTRL) || (wa == `MME_OFF_RESUME) || wr_mode_only;
  // range setup and table load refused outside the mode
  wire wr_ok = wr_mapped && (!wr_mode_only || in_mode);
  wire wr_go = wr_fire && wr_ok;
  wire entering = state == ST_INIT;
  wire [31:0] rd_mux =
    (araddr == `MME_OFF_STATUS) ? {26'h0, state, 2'b00, vt_loaded, in_mode} :
    (araddr == `MME_OFF_BASE) ? mgmt_base_addr :
    (araddr == `MME_OFF_CW0) ? ctrl_word_zero :
    (araddr == `MME_OFF_CW4) ? ctrl_word_four :
    (araddr == `MME_OFF_FLAGS) ? flags_reg :
    (araddr == `MME_OFF_IP) ? instr_pointer :
    (araddr == `MME_OFF_CSSEL) ? {16'h0, cs_sel} :
    (araddr == `MME_OFF_CSBASE) ? cs_base :
    (araddr == `MME_OFF_DCTRL) ? debug_ctrl_reg :
    (araddr == `MME_OFF_RBASE) ? rng_base :
    (araddr == `MME_OFF_RMASK) ? rng_mask : `MME_ZERO32;
  wire rd_mapped = (araddr <= `MME_OFF_RMASK) && (araddr[1:0] == 2'b00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      wa <= 8'h00;
      wd <= `MME_ZERO32;
      ws <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `MME_RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_hold <= 1'b1;
        awready <= 1'b0;
        wa <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold <= 1'b1;
        wready <= 1'b0;
        wd <= wdata;
        ws <= wstrb;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? `MME_RESP_OKAY : `MME_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= `MME_ZERO32;
      rresp <= `MME_RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_mapped ? `MME_RESP_OKAY : `MME_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // entry sequence; requests are ignored while in the mode
  wire req_seen = !req_lvl_n && state == ST_NORMAL;
  wire resume = wr_go && wa == `MME_OFF_RESUME && state == ST_MGMT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_NORMAL;
      in_mode <= 1'b0;
      fetch_start <= 1'b0;
      fetch_addr <= `MME_ZERO32;
    end else if (ce) begin
      fetch_start <= 1'b0;
      case (state)
        ST_NORMAL: begin
          if (req_seen) begin
            state <= ST_SAVE;
          end
        end
        ST_SAVE: begin
          if (ctx_saved) begin
            state <= ST_INIT;
          end
        end
        ST_INIT: begin
          // fetch is issued on the same edge that loads every entry value
          state <= ST_MGMT;
          in_mode <= 1'b1;
          fetch_start <= 1'b1;
          fetch_addr <= mgmt_base_addr + `MME_IP_ENTRY;
        end
        ST_MGMT: begin
          if (resume) begin
            state <= ST_NORMAL;
            in_mode <= 1'b0;
          end
        end
        default: begin
          state <= ST_NORMAL;
        end
      endcase
    end
  end

  // software registers, entry values take priority over bus writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mgmt_base_addr <= `MME_BASE_RST;
      ctrl_word_zero <= `MME_CW0_RST;
      ctrl_word_four <= `MME_ZERO32;
      flags_reg <= `MME_FLAGS_ENTRY;
      debug_ctrl_reg <= `MME_DCTRL_ENTRY;
      rng_base <= `MME_ZERO32;
      rng_mask <= `MME_ZERO32;
      vt_loaded <= 1'b0;
    end else if (ce) begin
      if (entering) begin
        ctrl_word_zero[`MME_BIT_PE] <= 1'b0;
        ctrl_word_zero[`MME_BIT_EM] <= 1'b0;
        ctrl_word_zero[`MME_BIT_TS] <= 1'b0;
        ctrl_word_zero[`MME_BIT_PG] <= 1'b0;
        ctrl_word_four <= `MME_ZERO32;
        flags_reg <= `MME_FLAGS_ENTRY;
        debug_ctrl_reg <= `MME_DCTRL_ENTRY;
        vt_loaded <= 1'b0;
      end else if (wr_go) begin
        if (wa == `MME_OFF_BASE) mgmt_base_addr <= merge(mgmt_base_addr, wd, ws);
        if (wa == `MME_OFF_CW0) ctrl_word_zero <= merge(ctrl_word_zero, wd, ws);
        if (wa == `MME_OFF_CW4) ctrl_word_four <= merge(ctrl_word_four, wd, ws);
        if (wa == `MME_OFF_FLAGS) flags_reg <= merge(flags_reg, wd, ws);
        if (wa == `MME_OFF_DCTRL) debug_ctrl_reg <= merge(debug_ctrl_reg, wd, ws);
        if (wa == `MME_OFF_RBASE) rng_base <= merge(rng_base, wd, ws);
        if (wa == `MME_OFF_RMASK) rng_mask <= merge(rng_mask, wd, ws);
        if (wa == `MME_OFF_VTAB) vt_loaded <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wire in_run = state == ST_MGMT;
  wire [31:0] xfer_ip = xfer_op32 ? xfer_off : {16'h0, xfer_off[15:0]};
  wire [31:0] acc_eff = adr_ovr ? acc_off : {16'h0, acc_off[15:0]};
  wire acc_idx_ok = acc_seg < 3'(NSEG);
  wire [2:0] acc_i = acc_idx_ok ? acc_seg : 3'd0;
  wire rng_hit = (rng_mask != `MME_ZERO32) && ((mem_addr & rng_mask) == (rng_base & rng_mask));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_pointer <= `MME_ZERO32;
      cs_sel <= 16'h0000;
      cs_base <= `MME_ZERO32;
      vec_addr <= `MME_ZERO32;
      push_ip <= 16'h0000;
    end else if (ce) begin
      if (entering) begin
        instr_pointer <= `MME_IP_ENTRY;
        cs_base <= mgmt_base_addr;
        cs_sel <= mgmt_base_addr[19:4];
      end else if (in_run && int_valid) begin
        vec_addr <= {22'h0, int_vec, 2'b00};
        push_ip <= instr_pointer[15:0];
        instr_pointer <= {16'h0, int_off};
        cs_sel <= int_sel;
        cs_base <= rm_base(int_sel);
      end else if (in_run && xfer_valid) begin
        instr_pointer <= xfer_ip;
        if (xfer_far) begin
          cs_sel <= xfer_sel;
          cs_base <= rm_base(xfer_sel);
        end
      end
    end
  end

  for (genvar g = 0; g < NSEG; g++) begin : g_seg
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        seg_sel[g] <= 16'h0000;
        seg_base[g] <= `MME_ZERO32;
        seg_limit[g] <= `MME_LIMIT_RM;
      end else if (ce) begin
        if (entering) begin
          seg_sel[g] <= 16'h0000;
          seg_base[g] <= `MME_ZERO32;
          seg_limit[g] <= `MME_LIMIT_4G;
        end else if (in_run && seg_ld_valid && seg_ld_idx == 3'(g)) begin
          seg_sel[g] <= seg_ld_val;
          seg_base[g] <= rm_base(seg_ld_val);
        end
      end
    end
  end

  // mode-dependent outputs and blocking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eff_op32 <= 1'b0;
      eff_adr32 <= 1'b0;
      phys_addr_ext_en <= 1'b0;
      acc_lin <= `MME_ZERO32;
      acc_fault <= 1'b0;
      mem_cacheable <= 1'b0;
      nmi_block <= 1'b0;
      mgmt_irq_block <= 1'b0;
      addr_line20_mask_irq_block <= 1'b0;
      init_block <= 1'b0;
      intr_enable <= 1'b0;
      exc_enable <= 1'b1;
      soft_int_enable <= 1'b1;
    end else if (ce) begin
      eff_op32 <= op_ovr;
      eff_adr32 <= adr_ovr;
      phys_addr_ext_en <= ctrl_word_four[`MME_BIT_PAE] && !in_mode;
      if (acc_valid) begin
        acc_lin <= seg_base[acc_i] + acc_eff;
        acc_fault <= !acc_idx_ok || acc_eff > seg_limit[acc_i];
      end
      mem_cacheable <= !(rng_hit && !in_mode);
      nmi_block <= in_mode || entering;
      mgmt_irq_block <= in_mode || entering;
      addr_line20_mask_irq_block <= in_mode || entering;
      init_block <= in_mode || entering;
      intr_enable <= flags_reg[`MME_BIT_IF] && !entering;
      exc_enable <= !(in_mode || entering) || vt_loaded;
      soft_int_enable <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  entry_cw0_a: assert property (entering ##1 ce |-> ctrl_word_zero[`MME_BIT_PE] == 1'b0 &&
      ctrl_word_zero[`MME_BIT_PG] == 1'b0 && ctrl_word_zero[30:4] == $past(ctrl_word_zero[30:4]))
    else $error("control word zero entry value wrong");
  entry_ip_a: assert property (fetch_start |-> instr_pointer == `MME_IP_ENTRY && in_mode)
    else $error("first fetch without entry pointer");
  entry_cs_a: assert property (entering |=> cs_base == $past(mgmt_base_addr) &&
      cs_sel == $past(mgmt_base_addr[19:4]))
    else $error("code segment entry value wrong");
  entry_flags_a: assert property (entering |=> flags_reg == `MME_FLAGS_ENTRY && !intr_enable)
    else $error("flags entry value wrong");
  entry_regs_a: assert property (entering |=> ctrl_word_four == `MME_ZERO32 &&
      debug_ctrl_reg == `MME_DCTRL_ENTRY && seg_limit[0] == `MME_LIMIT_4G)
    else $error("entry register values wrong");
  entry_block_a: assert property ($rose(in_mode) |-> nmi_block && mgmt_irq_block && addr_line20_mask_irq_block && init_block)
    else $error("requests not blocked on entry");
  no_reentry_a: assert property (in_mode && !resume |=> state == ST_MGMT)
    else $error("request left the mode");
  ip_trunc_a: assert property (in_run && xfer_valid && !int_valid && !xfer_op32 |=>
      instr_pointer[31:16] == 16'h0000)
    else $error("pointer not truncated");
  far_base_a: assert property (in_run && (xfer_valid || int_valid) |=> cs_base[31:20] == 12'h000)
    else $error("far base beyond 20 bits");
  push_ip_a: assert property (in_run && int_valid |=> push_ip == $past(instr_pointer[15:0]) &&
      instr_pointer[31:16] == 16'h0000 && vec_addr[1:0] == 2'b00)
    else $error("interrupt frame wrong");
  seg_load_a: assert property (in_run && seg_ld_valid && seg_ld_idx == 3'd2 |=>
      seg_base[2] == {12'h000, $past(seg_ld_val), 4'h0} && $stable(seg_limit[2]))
    else $error("segment load base wrong");
  range_cache_a: assert property (rng_hit && !in_mode ##1 ce |-> !mem_cacheable)
    else $error("range cacheable outside mode");

  entry_c: cover property (req_seen ##[1:20] fetch_start);
  int_c: cover property (in_run && int_valid);
  resume_c: cover property (resume ##1 state == ST_NORMAL);
endmodule

// >>> dv/mme_platform_model.sv
// platform model that pulls the management entry request pin low
module mme_platform_model (
  // clock
  input wire logic aclk,
  // command from the bench
  input wire logic req,
  input wire logic [3:0] lag,
  // request pin, pulled up when released
  output logic mgmt_irq_req_n
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] cnt;

  initial begin
    cnt = 4'h0;
    mgmt_irq_req_n = 1'b1;
  end

  // lag lets the bench model a slow platform as well as a prompt one
  always @(posedge aclk) begin
    if (!req) begin
      cnt <= 4'h0;
      mgmt_irq_req_n <= 1'b1;
    end else if (cnt < lag) begin
      cnt <= cnt + 4'h1;
    end else begin
      mgmt_irq_req_n <= 1'b0;
    end
  end
endmodule

// >>> dv/tb_top.sv
// self-checking bench of the management mode entry unit
`include "mme_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, int_vec;
  logic [31:0] wdata, rdata, xfer_off, acc_off, mem_addr, d;
  logic [3:0] wstrb, lag;
  logic [1:0] bresp, rresp, r;
  logic pin_n, req, ctx_saved, op_ovr, adr_ovr, xfer_valid, xfer_far, xfer_op32, int_valid, seg_ld_valid, acc_valid;
  logic [15:0] xfer_sel, int_sel, int_off, seg_ld_val, cs_sel, push_ip;
  logic [2:0] seg_ld_idx, acc_seg;
  logic in_mode, fetch_start, eff_op32, eff_adr32, phys_addr_ext_en, acc_fault, mem_cacheable;
  logic [31:0] fetch_addr, instr_pointer, cs_base, ctrl_word_zero, ctrl_word_four, flags_reg, debug_ctrl_reg;
  logic [31:0] acc_lin, vec_addr;
  logic nmi_block, mgmt_irq_block, addr_line20_mask_irq_block, init_block, intr_enable, exc_enable, soft_int_enable;
  int num_errors = 0;
  int compares = 0;
  int i;

  mme_platform_model u_mme_platform_model (.aclk(aclk), .req(req), .lag(lag), .mgmt_irq_req_n(pin_n));

  mme_entry_unit u_mme_entry_unit (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .mgmt_irq_req_n(pin_n), .ctx_saved(ctx_saved), .op_ovr(op_ovr),
    .adr_ovr(adr_ovr), .xfer_valid(xfer_valid), .xfer_far(xfer_far), .xfer_op32(xfer_op32),
    .xfer_sel(xfer_sel), .xfer_off(xfer_off), .int_valid(int_valid), .int_vec(int_vec), .int_sel(int_sel),
    .int_off(int_off), .seg_ld_valid(seg_ld_valid), .seg_ld_idx(seg_ld_idx), .seg_ld_val(seg_ld_val),
    .acc_valid(acc_valid), .acc_seg(acc_seg), .acc_off(acc_off), .mem_addr(mem_addr), .in_mode(in_mode),
    .fetch_start(fetch_start), .fetch_addr(fetch_addr), .instr_pointer(instr_pointer), .cs_sel(cs_sel),
    .cs_base(cs_base), .ctrl_word_zero(ctrl_word_zero), .ctrl_word_four(ctrl_word_four),
    .flags_reg(flags_reg), .debug_ctrl_reg(debug_ctrl_reg), .eff_op32(eff_op32), .eff_adr32(eff_adr32),
    .phys_addr_ext_en(phys_addr_ext_en), .acc_lin(acc_lin), .acc_fault(acc_fault), .vec_addr(vec_addr),
    .push_ip(push_ip), .mem_cacheable(mem_cacheable), .nmi_block(nmi_block),
    .mgmt_irq_block(mgmt_irq_block), .addr_line20_mask_irq_block(addr_line20_mask_irq_block), .init_block(init_block),
    .intr_enable(intr_enable), .exc_enable(exc_enable), .soft_int_enable(soft_int_enable)
  );

  initial aclk = 1'b0;
  always #4 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task test_done;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // outputs are looked at 1 ns after the edge, once its updates have landed
  task settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
    for (i = 0; i < 100 && !(ad && wd); i++) begin
      @(posedge aclk);
      if (!ad && awready === 1'b1) begin ad = 1'b1; awvalid <= 1'b0; end
      if (!wd && wready === 1'b1) begin wd = 1'b1; wvalid <= 1'b0; end
    end
    bready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (bvalid === 1'b1) break;
    end
    resp = bresp;
    bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (arready === 1'b1) break;
    end
    arvalid <= 1'b0; rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (rvalid === 1'b1) break;
    end
    v = rdata; resp = rresp;
    rready <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task seg(input logic [2:0] idx, input logic [15:0] v);
    @(posedge aclk); seg_ld_valid <= 1'b1; seg_ld_idx <= idx; seg_ld_val <= v;
    @(posedge aclk); seg_ld_valid <= 1'b0; settle(1);
  endtask

  // the override is set one edge early; the access path reads adr_ovr directly, only the eff_adr32 size flag lags by one cycle
  task acc(input logic [2:0] s, input logic [31:0] off, input logic ovr);
    @(posedge aclk); adr_ovr <= ovr;
    @(posedge aclk); acc_valid <= 1'b1; acc_seg <= s; acc_off <= off;
    @(posedge aclk); acc_valid <= 1'b0; settle(1);
  endtask

  task xfer(input logic far, input logic op32, input logic [15:0] sel, input logic [31:0] off);
    @(posedge aclk); xfer_valid <= 1'b1; xfer_far <= far; xfer_op32 <= op32; xfer_sel <= sel; xfer_off <= off;
    @(posedge aclk); xfer_valid <= 1'b0; settle(1);
  endtask

  task intr(input logic [7:0] v, input logic [15:0] sel, input logic [15:0] off);
    @(posedge aclk); int_valid <= 1'b1; int_vec <= v; int_sel <= sel; int_off <= off;
    @(posedge aclk); int_valid <= 1'b0; settle(1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    num_errors++;
    test_done;
  end

  initial begin
    aresetn = 1'b0; ce = 1'b1; awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'hf; wvalid = 1'b0;
    bready = 1'b0; araddr = 8'h00; arvalid = 1'b0; rready = 1'b0; req = 1'b0; lag = 4'h0; ctx_saved = 1'b0;
    op_ovr = 1'b0; adr_ovr = 1'b0; xfer_valid = 1'b0; xfer_far = 1'b0; xfer_op32 = 1'b0; xfer_sel = 16'h0;
    xfer_off = 32'h0; int_valid = 1'b0; int_vec = 8'h0; int_sel = 16'h0; int_off = 16'h0; seg_ld_valid = 1'b0;
    seg_ld_idx = 3'h0; seg_ld_val = 16'h0; acc_valid = 1'b0; acc_seg = 3'h0; acc_off = 32'h0; mem_addr = 32'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`MME_OFF_BASE, d, r); chk("base", d, 32'h0003_0000);
    rd(8'h3c, d, r); chk("unmapped resp", r, 2'b10);
    wr(`MME_OFF_RBASE, 32'h0003_0000, r); chk("range outside", r, 2'b10);
    $display("test reset done");
    // dirty the entry registers cw0, cw4, flags and debug ctrl first so that each load is seen
    wr(`MME_OFF_CW0, 32'hffff_ffff, r);
    wr(`MME_OFF_CW4, 32'h0000_0020, r);
    wr(`MME_OFF_FLAGS, 32'h0000_0302, r);
    wr(`MME_OFF_DCTRL, 32'h0000_00ff, r);
    wr(`MME_OFF_BASE, 32'h0004_0000, r);
    settle(2); chk("ext before", phys_addr_ext_en, 1);
    @(posedge aclk); lag <= 4'h3; req <= 1'b1; ctx_saved <= 1'b1;
    for (i = 0; i < 40 && fetch_start !== 1'b1; i++) settle(1);
    chk("fetch addr", fetch_addr, 32'h0004_8000);
    chk("in mode", in_mode, 1);
    chk("cw0", ctrl_word_zero, 32'h7fff_fff2);
    chk("cw4", ctrl_word_four, 0);
    chk("flags", flags_reg, 32'h2);
    chk("ip", instr_pointer, 32'h8000);
    chk("cs sel", cs_sel, 16'h4000);
    chk("cs base", cs_base, 32'h0004_0000);
    chk("debug ctrl", debug_ctrl_reg, 32'h400);
    settle(1);
    chk("fetch pulse", fetch_start, 0);
    chk("ext in mode", phys_addr_ext_en, 0);
    chk("blocks", {nmi_block, mgmt_irq_block, addr_line20_mask_irq_block, init_block}, 4'hf);
    chk("enables", {intr_enable, exc_enable, soft_int_enable}, 3'b001);
    chk("sizes", {eff_op32, eff_adr32}, 2'b00);
    @(posedge aclk); req <= 1'b0; ctx_saved <= 1'b0;
    $display("test entry done");
    acc(3'd1, 32'h10, 1'b0); chk("flat lin", acc_lin, 32'h10);
    seg(3'd2, 16'h1234); acc(3'd2, 32'h10, 1'b0); chk("seg lin", acc_lin, 32'h0001_2350);
    // without the override the offset wraps to 16 bits, so nothing beyond 64 KByte past the segment base is reached
    acc(3'd0, 32'h0020_0000, 1'b0); chk("high fault", acc_fault, 0);
    chk("high wrap", acc_lin, 32'h0000_0000);
    acc(3'd0, 32'h0020_0000, 1'b1); chk("high ovr", acc_fault, 0);
    chk("high lin", acc_lin, 32'h0020_0000);
    chk("adr size", eff_adr32, 1);
    op_ovr <= 1'b1; settle(2); chk("op size", eff_op32, 1);
    op_ovr <= 1'b0;
    xfer(1'b0, 1'b0, 16'h0, 32'h0001_2345); chk("near16", instr_pointer, 32'h2345);
    xfer(1'b0, 1'b1, 16'h0, 32'h0001_2345); chk("near32", instr_pointer, 32'h0001_2345);
    intr(8'h08, 16'h1000, 16'h0200); chk("push ip", push_ip, 16'h2345);
    chk("vector", vec_addr, 32'h20);
    chk("int ip", instr_pointer, 32'h200);
    xfer(1'b1, 1'b0, 16'hf000, 32'h10); chk("far base", cs_base, 32'h000f_0000);
    $display("test addressing done");
    wr(`MME_OFF_FLAGS, 32'h0000_0202, r); settle(2); chk("intr on", intr_enable, 1);
    wr(`MME_OFF_VTAB, 32'h1, r); settle(2); chk("exc on", exc_enable, 1);
    wr(`MME_OFF_RBASE, 32'h0003_0000, r); chk("range resp", r, 2'b00);
    wr(`MME_OFF_RMASK, 32'hffff_0000, r);
    mem_addr <= 32'h0003_0010;
    settle(2); chk("cache in", mem_cacheable, 1);
    rd(`MME_OFF_CW0, d, r); chk("cw0 bus", d, 32'h7fff_fff2);
    wr(`MME_OFF_RESUME, 32'h0, r); settle(3); chk("left", in_mode, 0);
    chk("cache out", mem_cacheable, 0);
    $display("test mode done");
    test_done;
  end
endmodule
